/* File: inc/pe_pkg.sv */
package pe_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [11:0] ADDR_PIN_VALUE     = 12'h000;
    localparam logic [11:0] ADDR_OUTPUT_LATCH  = 12'h004;
    localparam logic [11:0] ADDR_DIRECTION     = 12'h008;
    localparam logic [11:0] ADDR_ANALOG_SELECT = 12'h00c;
    localparam logic [11:0] ADDR_SLEW_CONTROL  = 12'h010;
    localparam logic [11:0] ADDR_PULLUP_CTRL   = 12'h014;
    localparam logic [11:0] ADDR_CONFIG        = 12'h018;

    // Field positions.
    localparam int PIN3_BIT         = 3;
    localparam int PULLUP_EN_BIT    = 7;
    localparam int GLOBAL_PU_DIS    = 7;
    localparam int SLEW_E_BIT       = 4;
    localparam int SLEW_LO_BIT      = 0;
    localparam int CFG_MASTER_CLEAR_RESET_N_EN_BIT  = 0;
    localparam int CFG_REMAP_BIT    = 1;

    // Implemented-bit masks.
    localparam logic [7:0] IO_MASK        = 8'h07;
    localparam logic [7:0] PIN_VALUE_MASK = 8'h0f;
    localparam logic [7:0] DIR_MASK       = 8'h87;
    localparam logic [7:0] SLEW_MASK      = 8'h1f;
    localparam logic [7:0] PULLUP_MASK    = 8'h80;
    localparam logic [7:0] CONFIG_MASK    = 8'h03;

    // Reset values.
    localparam logic [7:0] ANALOG_RESET  = 8'h07;
    localparam logic [7:0] DIR_RESET     = 8'h07;
    localparam logic [7:0] LATCH_RESET   = 8'h00;
    localparam logic [7:0] SLEW_RESET    = 8'h1f;
    localparam logic [7:0] PULLUP_RESET  = 8'h80;
    localparam logic [7:0] CONFIG_RESET  = 8'h01;

    typedef enum logic [1:0] {
        PE_SRC_LATCH,
        PE_SRC_CMP,
        PE_SRC_PWM
    } pe_src_t;
endpackage : pe_pkg

/* File: hw/pe_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module pe_pin_mux (
    // Controls
    input  wire logic pwm_en,
    input  wire logic pwm_val,
    input  wire logic cmp_en,
    input  wire logic cmp_val,
    input  wire logic latch_val,
    input  wire logic dir_in,
    // Driver
    output logic      pin_out,
    output logic      pin_oe
);
    pe_pkg::pe_src_t src;

    // The enhanced PWM outranks compare, which outranks the port latch.
    always_comb begin
        if (pwm_en) begin
            src = pe_pkg::PE_SRC_PWM;
        end else if (cmp_en) begin
            src = pe_pkg::PE_SRC_CMP;
        end else begin
            src = pe_pkg::PE_SRC_LATCH;
        end
    end

    always_comb begin
        case (src)
            pe_pkg::PE_SRC_PWM: pin_out = pwm_val;
            pe_pkg::PE_SRC_CMP: pin_out = cmp_val;
            default:            pin_out = latch_val;
        endcase
    end

    // Analog select never reaches here, so analog pins still drive.
    assign pin_oe = !dir_in;
endmodule : pe_pin_mux
`default_nettype wire

/* File: hw/pe_pin_sample.sv */
`timescale 1ns/1ps
`default_nettype none
module pe_pin_sample #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Data
    input  wire logic [WIDTH-1:0] pin_in,
    input  wire logic [WIDTH-1:0] buf_dis,
    output logic      [WIDTH-1:0] sampled_ff
);
    logic [WIDTH-1:0] nxt_sampled;

    // A disabled input buffer reads low whatever the pad does.
    assign nxt_sampled = pin_in & ~buf_dis;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sampled_ff <= '0;
        end else begin
            sampled_ff <= nxt_sampled;
        end
    end
endmodule : pe_pin_sample
`default_nettype wire

/* File: hw/pe_port_e.sv */
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pe_port_e #(
    parameter int NPINS = 3
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    // Pads
    input  wire logic [3:0]  pin_in,
    output logic      [2:0]  pin_out,
    output logic      [2:0]  pin_oe,
    output logic             pin3_pullup_on,
    output logic      [4:0]  slew_limit,
    output logic      [2:0]  analog_enable,
    // Peripherals
    input  wire logic        unit3_pwm_a_en,
    input  wire logic        unit3_pwm_out_a,
    input  wire logic        unit3_pwm_b_en,
    input  wire logic        unit3_pwm_out_b,
    input  wire logic        unit3_cmp_en,
    input  wire logic        unit3_cmp_out,
    input  wire logic        unit5_cmp_en,
    input  wire logic        unit5_cmp_out,
    output logic             unit3_capture_in,
    output logic             unit5_capture_in,
    // Reset request
    output logic             master_clear_reset_n
);
    logic [7:0] analog_ff;
    logic [7:0] latch_ff;
    logic [7:0] dir_ff;
    logic [7:0] slew_ff;
    logic [7:0] pullup_ctrl_ff;
    logic [7:0] config_ff;
    logic [3:0] sampled_ff;
    logic [3:0] buf_dis;
    logic [2:0] pwm_en;
    logic [2:0] pwm_val;
    logic [2:0] cmp_en;
    logic [2:0] cmp_val;
    logic       wr_en;
    logic       master_clear_reset_n_mode;
    logic       remap_clear;
    logic [7:0] rd_val;
    logic       hit;

    function automatic logic [7:0] wbyte(input logic [31:0] d, input logic [7:0] m);
        wbyte = d[7:0] & m;
    endfunction : wbyte

    // Zero-wait slave: every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign pslverr = psel && penable && !hit;

    assign master_clear_reset_n_mode   = config_ff[pe_pkg::CFG_MASTER_CLEAR_RESET_N_EN_BIT];
    assign remap_clear = !config_ff[pe_pkg::CFG_REMAP_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_ff <= pe_pkg::ANALOG_RESET;
        end else if (wr_en && paddr == pe_pkg::ADDR_ANALOG_SELECT) begin
            analog_ff <= wbyte(pwdata, pe_pkg::IO_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_ff <= pe_pkg::DIR_RESET;
        end else if (wr_en && paddr == pe_pkg::ADDR_DIRECTION) begin
            dir_ff <= wbyte(pwdata, pe_pkg::DIR_MASK);
        end
    end

    // The pin-value and latch addresses both write the latch.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_ff <= pe_pkg::LATCH_RESET;
        end else if (wr_en && (paddr == pe_pkg::ADDR_OUTPUT_LATCH ||
                               paddr == pe_pkg::ADDR_PIN_VALUE)) begin
            latch_ff <= wbyte(pwdata, pe_pkg::IO_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slew_ff <= pe_pkg::SLEW_RESET;
        end else if (wr_en && paddr == pe_pkg::ADDR_SLEW_CONTROL) begin
            slew_ff <= wbyte(pwdata, pe_pkg::SLEW_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_ctrl_ff <= pe_pkg::PULLUP_RESET;
        end else if (wr_en && paddr == pe_pkg::ADDR_PULLUP_CTRL) begin
            pullup_ctrl_ff <= wbyte(pwdata, pe_pkg::PULLUP_MASK);
        end
    end

    // Configuration bits would be fuses; here software may set them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_ff <= pe_pkg::CONFIG_RESET;
        end else if (wr_en && paddr == pe_pkg::ADDR_CONFIG) begin
            config_ff <= wbyte(pwdata, pe_pkg::CONFIG_MASK);
        end
    end

    always_comb begin
        hit    = 1'b1;
        rd_val = 8'h00;
        case (paddr)
            pe_pkg::ADDR_PIN_VALUE:     rd_val = {4'h0, sampled_ff};
            pe_pkg::ADDR_OUTPUT_LATCH:  rd_val = latch_ff & pe_pkg::IO_MASK;
            pe_pkg::ADDR_DIRECTION:     rd_val = dir_ff & pe_pkg::DIR_MASK;
            pe_pkg::ADDR_ANALOG_SELECT: rd_val = analog_ff & pe_pkg::IO_MASK;
            pe_pkg::ADDR_SLEW_CONTROL:  rd_val = slew_ff & pe_pkg::SLEW_MASK;
            pe_pkg::ADDR_PULLUP_CTRL:   rd_val = pullup_ctrl_ff & pe_pkg::PULLUP_MASK;
            pe_pkg::ADDR_CONFIG:        rd_val = config_ff & pe_pkg::CONFIG_MASK;
            default:                    hit = 1'b0;
        endcase
    end

    // Read data is registered in the setup cycle so it is ready at access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_val};
        end
    end

    // Pin 3 reads 0 while it serves as master clear.
    assign buf_dis = {master_clear_reset_n_mode, analog_ff[2:0]};

    pe_pin_sample #(
        .WIDTH(4)
    ) u_sample (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    (pin_in),
        .buf_dis   (buf_dis),
        .sampled_ff(sampled_ff)
    );

    // Per-pin peripheral assignment; pin 0 only when not remapped away.
    assign pwm_en  = {1'b0, unit3_pwm_b_en, unit3_pwm_a_en && remap_clear};
    assign pwm_val = {1'b0, unit3_pwm_out_b, unit3_pwm_out_a};
    assign cmp_en  = {unit5_cmp_en, 1'b0, unit3_cmp_en && remap_clear};
    assign cmp_val = {unit5_cmp_out, 1'b0, unit3_cmp_out};

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            pe_pin_mux u_mux (
                .pwm_en   (pwm_en[g]),
                .pwm_val  (pwm_val[g]),
                .cmp_en   (cmp_en[g]),
                .cmp_val  (cmp_val[g]),
                .latch_val(latch_ff[g]),
                .dir_in   (dir_ff[g]),
                .pin_out  (pin_out[g]),
                .pin_oe   (pin_oe[g])
            );
        end
    endgenerate

    // Capture inputs see the same gated sample as the pin-value read.
    // The live select bit gates too, so the sample taken before it was set never leaks.
    assign unit3_capture_in = remap_clear && dir_ff[0] && !analog_ff[0] && sampled_ff[0];
    assign unit5_capture_in = dir_ff[2] && !analog_ff[2] && sampled_ff[2];

    assign analog_enable = analog_ff[2:0];
    assign slew_limit    = slew_ff[4:0];

    assign pin3_pullup_on = master_clear_reset_n_mode ||
        (dir_ff[pe_pkg::PULLUP_EN_BIT] && !pullup_ctrl_ff[pe_pkg::GLOBAL_PU_DIS]);

    // Reset request is the raw pad level; the reset controller filters it.
    assign master_clear_reset_n = master_clear_reset_n_mode ? pin_in[pe_pkg::PIN3_BIT] : 1'b1;
endmodule : pe_port_e
`default_nettype wire

/* File: verification/pe_port_e_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pe_port_e_properties (
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Pads
    input wire logic [3:0] pin_in,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic       pin3_pullup_on,
    input wire logic [2:0] analog_enable,
    // Peripherals
    input wire logic       unit3_pwm_b_en,
    input wire logic       unit3_pwm_out_b,
    input wire logic       unit5_cmp_en,
    input wire logic       unit5_cmp_out,
    input wire logic       unit3_capture_in,
    input wire logic       unit5_capture_in,
    input wire logic       master_clear_reset_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ana_rst; $rose(presetn) |-> analog_enable == 3'h7; endproperty
    a_ana_rst: assert property (p_ana_rst) else $error("analog select not set");
    property p_oe_rst; $rose(presetn) |-> pin_oe == 3'h0; endproperty
    a_oe_rst: assert property (p_oe_rst) else $error("driver on after reset");
    property p_pu_rst; $rose(presetn) |-> pin3_pullup_on; endproperty
    a_pu_rst: assert property (p_pu_rst) else $error("pull-up off in clear mode");
    property p_master_clear_reset_n; !master_clear_reset_n |-> !pin_in[3]; endproperty
    a_master_clear_reset_n: assert property (p_master_clear_reset_n) else $error("reset request without low pin");
    property p_cap3; analog_enable[0] |-> !unit3_capture_in; endproperty
    a_cap3: assert property (p_cap3) else $error("capture 3 not gated");
    property p_cap5; analog_enable[2] |-> !unit5_capture_in; endproperty
    a_cap5: assert property (p_cap5) else $error("capture 5 not gated");
    property p_pwmb; unit3_pwm_b_en && pin_oe[1] |-> pin_out[1] == unit3_pwm_out_b; endproperty
    a_pwmb: assert property (p_pwmb) else $error("pin 1 not owned by pwm");
    property p_cmp5; unit5_cmp_en && pin_oe[2] |-> pin_out[2] == unit5_cmp_out; endproperty
    a_cmp5: assert property (p_cmp5) else $error("pin 2 not owned by compare");
endmodule : pe_port_e_properties
bind pe_port_e pe_port_e_properties pe_port_e_properties_i (.pclk, .presetn, .pin_in,
    .pin_out, .pin_oe, .pin3_pullup_on, .analog_enable, .unit3_pwm_b_en, .unit3_pwm_out_b,
    .unit5_cmp_en, .unit5_cmp_out, .unit3_capture_in, .unit5_capture_in,
    .master_clear_reset_n);
`default_nettype wire

/* File: verification/pe_board.sv */
`timescale 1ns/1ps
`default_nettype none
module pe_board (
    // Device side
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    input  wire logic       pin3_pullup_on,
    // Board stimulus
    input  wire logic [3:0] ext,
    input  wire logic       ext3_float,
    output logic      [3:0] pin_in
);
    assign pin_in[2:0] = (pin_oe & pin_out) | (~pin_oe & ext[2:0]);
    // A floating pin 3 has a weak board pull-down, so only the pull-up lifts it.
    assign pin_in[3] = ext3_float ? pin3_pullup_on : ext[3];
endmodule : pe_board
`default_nettype wire

/* File: verification/test_pe_port_e.sv */
`timescale 1ns/1ps
`default_nettype none
module test_pe_port_e;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  per = 8'h00;
    logic [3:0]  ext = 4'h0;
    logic        flt = 1'b0;
    logic        pready, pslverr, pin3_pullup_on, u3cap, u5cap, master_clear_reset_n_n;
    logic [31:0] prdata;
    logic [3:0]  pin_in;
    logic [2:0]  pin_out, pin_oe, analog_enable;
    logic [4:0]  slew_limit;
    logic [7:0]  lat, v;
    logic [32:0] q[$];
    int          miscompares = 0;
    int          n_checks = 0;
    always #5 pclk = ~pclk;
    pe_port_e pe_port_e_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .pin_in, .pin_out, .pin_oe, .pin3_pullup_on,
        .slew_limit, .analog_enable, .unit3_pwm_a_en(per[0]), .unit3_pwm_out_a(per[1]),
        .unit3_cmp_en(per[2]), .unit3_cmp_out(per[3]), .unit3_pwm_b_en(per[4]),
        .unit3_pwm_out_b(per[5]), .unit5_cmp_en(per[6]), .unit5_cmp_out(per[7]),
        .unit3_capture_in(u3cap), .unit5_capture_in(u5cap), .master_clear_reset_n(master_clear_reset_n_n));
    pe_board pe_board_i (.pin_out, .pin_oe, .pin3_pullup_on, .ext, .ext3_float(flt), .pin_in);
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic w = 1'b1);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic err = 1'b0);
        q.push_back({err, 24'h0, e});
        wr(a, 8'h00, 1'b0);
    endtask : rd
    task automatic pads(input logic [2:0] oe, input logic [2:0] out);
        @(negedge pclk);
        chk(33'(pin_oe), 33'(oe));
        chk(33'(pin_out & pin_oe), 33'(out & oe));
    endtask : pads
    function automatic logic [2:0] drive(input logic [7:0] p, input logic rm);
        return {p[6] ? p[7] : lat[2], p[4] ? p[5] : lat[1],
                !rm && p[0] ? p[1] : !rm && p[2] ? p[3] : lat[0]};
    endfunction : drive
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0)
            chk({pslverr, prdata}, q.pop_front());
    end
    task automatic final_report;
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        final_report();
    end
    initial begin
        void'($urandom(32'h3256));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(pe_pkg::ADDR_ANALOG_SELECT, 8'h07);
        rd(pe_pkg::ADDR_DIRECTION, 8'h07);
        rd(pe_pkg::ADDR_SLEW_CONTROL, 8'h1f);
        rd(pe_pkg::ADDR_PULLUP_CTRL, 8'h80);
        rd(pe_pkg::ADDR_CONFIG, 8'h01);
        rd(pe_pkg::ADDR_PIN_VALUE, 8'h00);
        rd(12'h01c, 8'h00, 1'b1);
        pads(3'h0, 3'h0);
        $display("test reset done");
        wr(pe_pkg::ADDR_ANALOG_SELECT, 8'h00);
        wr(pe_pkg::ADDR_DIRECTION, 8'h00);
        for (int i = 0; i < 4; i++) begin
            lat = 8'($urandom);
            wr(pe_pkg::ADDR_PIN_VALUE, lat);
            rd(pe_pkg::ADDR_OUTPUT_LATCH, lat & 8'h07);
            rd(pe_pkg::ADDR_PIN_VALUE, lat & 8'h07);
            pads(3'h7, lat[2:0]);
        end
        wr(pe_pkg::ADDR_ANALOG_SELECT, 8'h07);
        rd(pe_pkg::ADDR_PIN_VALUE, 8'h00);
        pads(3'h7, lat[2:0]);
        $display("test output done");
        wr(pe_pkg::ADDR_DIRECTION, 8'h07);
        wr(pe_pkg::ADDR_CONFIG, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(pe_pkg::ADDR_ANALOG_SELECT, i[0] ? 8'h07 : 8'h00);
            v = 8'($urandom);
            ext <= v[3:0];
            repeat (2) @(posedge pclk);
            rd(pe_pkg::ADDR_PIN_VALUE, v & (i[0] ? 8'h08 : 8'h0f));
            pads(3'h0, 3'h0);
            chk(33'(u3cap), 33'(v[0] & !i[0]));
            chk(33'(u5cap), 33'(v[2] & !i[0]));
        end
        $display("test input done");
        wr(pe_pkg::ADDR_DIRECTION, 8'h00);
        for (int i = 0; i < 10; i++) begin
            v = (i < 8) ? 8'($urandom) : {6'h0, ~lat[0], 1'b1};
            @(posedge pclk);
            per <= v;
            if (i == 9)
                wr(pe_pkg::ADDR_CONFIG, 8'h02);
            pads(3'h7, drive(v, i == 9));
        end
        $display("test priority done");
        @(posedge pclk);
        flt <= 1'b1;
        wr(pe_pkg::ADDR_DIRECTION, 8'h80);
        wr(pe_pkg::ADDR_PULLUP_CTRL, 8'h00);
        rd(pe_pkg::ADDR_PIN_VALUE, 8'h08);
        wr(pe_pkg::ADDR_PULLUP_CTRL, 8'h80);
        rd(pe_pkg::ADDR_PIN_VALUE, 8'h00);
        wr(pe_pkg::ADDR_CONFIG, 8'h01);
        @(negedge pclk);
        chk(33'(master_clear_reset_n_n), 33'h1);
        @(posedge pclk);
        flt <= 1'b0;
        ext <= 4'h0;
        @(negedge pclk);
        chk(33'(master_clear_reset_n_n), 33'h0);
        $display("test pin3 done");
        wr(pe_pkg::ADDR_SLEW_CONTROL, 8'h00);
        @(negedge pclk);
        chk(33'(slew_limit), 33'h00);
        rd(pe_pkg::ADDR_SLEW_CONTROL, 8'h00);
        $display("test slew done");
        final_report();
    end
endmodule : test_pe_port_e
`default_nettype wire
